//--- logic/mmd_memory_map_decoder.sv
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
module mmd_memory_map_decoder (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [1:0] hresp,
    output logic [31:0] hrdata,
    input wire logic mode_a_pin,
    input wire logic mode_b_pin,
    input wire logic [15:0] cpu_addr,
    output logic sel_reg,
    output logic sel_ram,
    output logic sel_eeprom,
    output logic sel_rom,
    output logic [14:0] mem_offset
);
    import mmd_pkg::*;

    logic [1:0] mode_pins;
    logic [7:0] init_reg;
    logic [3:0] nvm_window_field;
    logic [7:0] cfg_reg;
    logic init_written;
    logic [6:0] startup_cnt;
    mmd_mode_type mode;
    logic mode_valid;
    logic wr_pend;
    logic [7:0] wr_idx;
    logic [7:0] next_init_reg;
    logic [3:0] next_nvm_window_field;
    logic [7:0] next_cfg_reg;
    logic next_init_written;
    logic [6:0] next_startup_cnt;
    mmd_mode_type next_mode;
    logic next_mode_valid;
    logic next_wr_pend;
    logic [7:0] next_wr_idx;
    logic [31:0] next_hrdata;
    logic next_sel_reg;
    logic next_sel_ram;
    logic next_sel_eeprom;
    logic next_sel_rom;
    logic [14:0] next_mem_offset;
    logic addr_go;
    logic addr_mapped;
    logic special;
    logic init_wr_ok;
    logic rom_on;
    logic rom_high;
    logic [11:0] off;
    logic [11:0] ram_end;

    mmd_pin_sync #(.WIDTH(2)) u_mode_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .pin_in({mode_b_pin, mode_a_pin}),
        .pin_sync(mode_pins)
    );

    assign addr_go = hsel && (htrans == HTRANS_NONSEQ) && hready;
    assign addr_mapped = (haddr[31:IDX_MSB+1] == '0) && (haddr[IDX_LSB-1:0] == '0);
    assign special = mode_valid && mmd_is_special(mode);
    assign init_wr_ok = special || (!init_written && (startup_cnt < INIT_WINDOW_CYCLES));

    // bus, configuration registers, start-up window and mode capture
    always_comb
    begin
        next_init_reg = init_reg;
        next_nvm_window_field = nvm_window_field;
        next_cfg_reg = cfg_reg;
        next_init_written = init_written;
        next_startup_cnt = startup_cnt;
        next_mode = mode;
        next_mode_valid = mode_valid;
        next_wr_pend = addr_go && hwrite && addr_mapped;
        next_wr_idx = addr_go ? haddr[IDX_MSB:IDX_LSB] : wr_idx;
        next_hrdata = hrdata;
        if (startup_cnt < INIT_WINDOW_CYCLES)
        begin
            next_startup_cnt = startup_cnt + 7'd1;
        end
        // synchroniser output settles on the fourth edge, so the straps are caught on the fifth
        if (!mode_valid && (startup_cnt == MODE_SETTLE_CYCLES))
        begin
            next_mode = mmd_mode_of(mode_pins[1], mode_pins[0]);
            next_mode_valid = 1'b1;
            if (next_mode == MODE_TEST)
            begin
                next_cfg_reg[CFG_ROM_PRESENT_ENABLE_BIT] = 1'b0;
            end
        end
        if (wr_pend)
        begin
            if ((wr_idx == IDX_INIT) && init_wr_ok)
            begin
                next_init_reg = hwdata[7:0];
                next_init_written = 1'b1;
            end
            if (wr_idx == IDX_NVM)
            begin
                next_nvm_window_field = hwdata[7:4];
            end
            if (wr_idx == IDX_CFG)
            begin
                next_cfg_reg = hwdata[7:0];
            end
        end
        if (addr_go && !hwrite)
        begin
            next_hrdata = '0;
            if (addr_mapped)
            begin
                unique case (haddr[IDX_MSB:IDX_LSB])
                    IDX_INIT: next_hrdata[7:0] = init_reg;
                    IDX_NVM: next_hrdata[7:4] = nvm_window_field;
                    IDX_CFG:
                    begin
                        next_hrdata[7:0] = cfg_reg;
                        next_hrdata[CFG_ONE_BIT] = 1'b1;
                    end
                    IDX_STATUS:
                    begin
                        next_hrdata[ST_MODE_LSB+:2] = mode;
                        next_hrdata[ST_VALID_BIT] = mode_valid;
                        next_hrdata[ST_OPEN_BIT] = init_wr_ok;
                        next_hrdata[ST_DONE_BIT] = init_written;
                    end
                    default: next_hrdata = '0;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            init_reg <= INIT_RESET;
            nvm_window_field <= NVM_RESET;
            cfg_reg <= CFG_RESET;
            init_written <= 1'b0;
            startup_cnt <= '0;
            mode <= MODE_SINGLE;
            mode_valid <= 1'b0;
            wr_pend <= 1'b0;
            wr_idx <= '0;
            hrdata <= '0;
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
        end
        else if (ce)
        begin
            init_reg <= next_init_reg;
            nvm_window_field <= next_nvm_window_field;
            cfg_reg <= next_cfg_reg;
            init_written <= next_init_written;
            startup_cnt <= next_startup_cnt;
            mode <= next_mode;
            mode_valid <= next_mode_valid;
            wr_pend <= next_wr_pend;
            wr_idx <= next_wr_idx;
            hrdata <= next_hrdata;
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
        end
    end

    // address decode of the cpu space, one cycle of latency
    assign rom_on = (mode == MODE_SINGLE) || cfg_reg[CFG_ROM_PRESENT_ENABLE_BIT];
    assign rom_high = (mode == MODE_SINGLE) || cfg_reg[CFG_ROM_HIGH_PLACEMENT_BIT];
    assign off = cpu_addr[11:0];
    assign ram_end = (init_reg[7:4] == init_reg[3:0]) ? RAM_RELOC_END : RAM_BYTES;

    always_comb
    begin
        next_sel_reg = 1'b0;
        next_sel_ram = 1'b0;
        next_sel_eeprom = 1'b0;
        next_sel_rom = 1'b0;
        next_mem_offset = '0;
        if ((cpu_addr[15:12] == init_reg[3:0]) && (off[11:7] == '0))
        begin
            next_sel_reg = 1'b1;
            next_mem_offset = {8'h00, off[6:0]};
        end
        else if ((cpu_addr[15:12] == init_reg[7:4]) && (off < ram_end))
        begin
            next_sel_ram = 1'b1;
            next_mem_offset = (off >= RAM_BYTES) ? {3'b000, off - RAM_BYTES} : {3'b000, off};
        end
        else if (cfg_reg[CFG_NVM_PRESENT_ENABLE_BIT] && (cpu_addr[15:12] == nvm_window_field)
                 && (off < EE_BYTES))
        begin
            next_sel_eeprom = 1'b1;
            next_mem_offset = {3'b000, off};
        end
        else if (rom_on && rom_high && (cpu_addr >= ROM_HIGH_BASE))
        begin
            next_sel_rom = 1'b1;
            next_mem_offset = 15'(cpu_addr - ROM_HIGH_BASE);
        end
        else if (rom_on && !rom_high && (cpu_addr >= ROM_LOW_BASE) && (cpu_addr <= ROM_LOW_LAST))
        begin
            next_sel_rom = 1'b1;
            next_mem_offset = 15'(cpu_addr - ROM_LOW_BASE);
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sel_reg <= 1'b0;
            sel_ram <= 1'b0;
            sel_eeprom <= 1'b0;
            sel_rom <= 1'b0;
            mem_offset <= '0;
        end
        else if (ce)
        begin
            sel_reg <= next_sel_reg;
            sel_ram <= next_sel_ram;
            sel_eeprom <= next_sel_eeprom;
            sel_rom <= next_sel_rom;
            mem_offset <= next_mem_offset;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_init_write;
        ce && wr_pend && (wr_idx == IDX_INIT) && init_wr_ok;
    endsequence

    sequence s_same_page_tail;
        ce && (init_reg[7:4] == init_reg[3:0]) && (cpu_addr[15:12] == init_reg[7:4])
            && (off >= RAM_BYTES) && (off < RAM_RELOC_END);
    endsequence

    a_one_target: assert property ($onehot0({sel_reg, sel_ram, sel_eeprom, sel_rom}))
        else $error("more than one target selected");
    a_reset_map: assert property ((startup_cnt == 7'd1) |-> (init_reg == INIT_RESET))
        else $error("mapping register not zero after reset");
    a_init_takes: assert property (s_init_write |=> (init_reg == $past(hwdata[7:0])))
        else $error("mapping write not taken");
    a_reg_hit: assert property (
        (ce && (cpu_addr[15:12] == init_reg[3:0]) && (off[11:7] == '0))
        |=> (sel_reg && (mem_offset[6:0] == $past(off[6:0]))))
        else $error("register block not decoded");
    a_ram_hit: assert property (
        (ce && (cpu_addr[15:12] == init_reg[7:4])
        && (cpu_addr[15:12] != init_reg[3:0]) && (off < RAM_BYTES)) |=> sel_ram)
        else $error("ram not decoded at its page");
    a_ram_reloc: assert property (
        s_same_page_tail
        |=> (sel_ram && (mem_offset == {3'b000, $past(off) - RAM_BYTES})))
        else $error("covered ram bytes not relocated");
    a_init_locked: assert property (
        (ce && !special && wr_pend && (wr_idx == IDX_INIT)
        && (init_written || (startup_cnt >= INIT_WINDOW_CYCLES))) |=> $stable(init_reg))
        else $error("mapping register changed outside its window");
    a_test_no_rom: assert property (
        (ce && (mode == MODE_TEST) && !cfg_reg[CFG_ROM_PRESENT_ENABLE_BIT])
        |=> !sel_rom)
        else $error("rom mapped in test mode while disabled");
    a_nvm_gate: assert property (
        (sel_eeprom && $past(ce))
        |-> ($past(cfg_reg[CFG_NVM_PRESENT_ENABLE_BIT]) && ($past(cpu_addr[15:12]) == $past(nvm_window_field))))
        else $error("eeprom selected while absent or off its page");
    a_bus_okay: assert property (hreadyout && (hresp == HRESP_OKAY))
        else $error("slave stalled or errored");
endmodule
`default_nettype wire

//--- logic/mmd_pkg.sv
// Contract
// - three config registers set presence and place of registers, RAM, EEPROM, ROM in 64K. In MODE_SINGLE ROM stays at ROM_HIGH_BASE whatever cfg_reg holds.
// - 128-byte register block decoded, sitting at address zero right after reset.
// - after reset, writing the mapping register moves the block to any 4K boundary.
// - special test mode starts with ROM absent; setting rom_present_enable maps it. Here ROM stays mapped until the straps are caught on the fifth edge.
// - mapping register upper nibble gives the RAM's upper four address bits.
// - mapping register lower nibble gives the register block's upper four address bits.
// - RAM bytes covered by the register block reappear right after the remaining RAM.
// - normal modes: mapping register written once within 64 cycles; special modes: anytime.
package mmd_pkg;
    // register indices, byte address is four times the index
    localparam logic [7:0] IDX_NVM = 8'h37;
    localparam logic [7:0] IDX_INIT = 8'h3d;
    localparam logic [7:0] IDX_CFG = 8'h3f;
    localparam logic [7:0] IDX_STATUS = 8'h40;
    localparam int unsigned IDX_LSB = 2;
    localparam int unsigned IDX_MSB = 9;
    localparam logic [7:0] INIT_RESET = 8'h00;
    localparam logic [3:0] NVM_RESET = 4'h0;
    localparam logic [7:0] CFG_RESET = 8'hc3;
    localparam int unsigned CFG_ROM_HIGH_PLACEMENT_BIT = 7;
    localparam int unsigned CFG_ONE_BIT = 6;
    localparam int unsigned CFG_ROM_PRESENT_ENABLE_BIT = 1;
    localparam int unsigned CFG_NVM_PRESENT_ENABLE_BIT = 0;
    localparam int unsigned ST_MODE_LSB = 0;
    localparam int unsigned ST_VALID_BIT = 2;
    localparam int unsigned ST_OPEN_BIT = 3;
    localparam int unsigned ST_DONE_BIT = 4;
    // address map
    localparam logic [11:0] RAM_BYTES = 12'h300;
    localparam logic [11:0] RAM_RELOC_END = 12'h380;
    localparam logic [11:0] EE_BYTES = 12'h280;
    localparam logic [15:0] ROM_LOW_BASE = 16'h2000;
    localparam logic [15:0] ROM_LOW_LAST = 16'h7fff;
    localparam logic [15:0] ROM_HIGH_BASE = 16'ha000;
    localparam logic [15:0] ROM_HIGH_LAST = 16'hffff;
    // timing, in hclk cycles
    localparam logic [6:0] INIT_WINDOW_CYCLES = 7'd64;
    localparam logic [6:0] MODE_SETTLE_CYCLES = 7'd4;
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [1:0] HRESP_OKAY = 2'b00;

    typedef enum logic [1:0] {MODE_SINGLE, MODE_EXPANDED, MODE_BOOT, MODE_TEST} mmd_mode_type;

    function automatic mmd_mode_type mmd_mode_of(input logic modb, input logic moda);
        mmd_mode_type m;
        m = MODE_SINGLE;
        case ({modb, moda})
            2'b10: m = MODE_SINGLE;
            2'b11: m = MODE_EXPANDED;
            2'b00: m = MODE_BOOT;
            default: m = MODE_TEST;
        endcase
        return m;
    endfunction

    function automatic logic mmd_is_special(input mmd_mode_type m);
        return (m == MODE_BOOT) || (m == MODE_TEST);
    endfunction
endpackage

//--- logic/mmd_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
// three-stage pin synchroniser; output moves once stages two and three agree
module mmd_pin_sync #(
    parameter int unsigned WIDTH = 2
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_sync
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] next_sync;

    always_comb
    begin
        next_sync = pin_sync;
        if (stage2 == stage3)
        begin
            next_sync = stage3;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            pin_sync <= '0;
        end
        else if (ce)
        begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
            pin_sync <= next_sync;
        end
    end
endmodule
`default_nettype wire

//--- verification/mmd_memory_map_decoder_test.sv
`timescale 1ns/100ps
`default_nettype none
module mmd_memory_map_decoder_test;
    import mmd_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    wire logic hready;
    logic hreadyout;
    logic [1:0] hresp;
    logic [31:0] hrdata;
    logic mode_a_pin = 1'b0;
    logic mode_b_pin = 1'b1;
    logic [15:0] cpu_addr = 16'h0;
    logic sel_reg;
    logic sel_ram;
    logic sel_eeprom;
    logic sel_rom;
    logic [14:0] mem_offset;
    logic [31:0] rd;
    int err_total = 0;
    int cmp_count = 0;
    int cycles = 0;
    // one slave on the bus, so its ready is the bus ready
    assign hready = hreadyout;
    always #5 hclk = ~hclk;
    mmd_memory_map_decoder uut (
        .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .mode_a_pin(mode_a_pin), .mode_b_pin(mode_b_pin), .cpu_addr(cpu_addr),
        .sel_reg(sel_reg), .sel_ram(sel_ram), .sel_eeprom(sel_eeprom),
        .sel_rom(sel_rom), .mem_offset(mem_offset)
    );
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge hclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            stop_test();
        end
    end
    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                       output logic [31:0] r);
        @(posedge hclk);
        haddr <= {22'h0, idx, 2'b00};
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        hsel <= 1'b1;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        bus(1'b1, idx, {24'h0, v}, rd);
    endtask
    task automatic chk_reg(input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 32'h0, rd);
        cmp_count++;
        if (rd !== {24'h0, exp} || hresp !== HRESP_OKAY)
        begin
            err_total++;
            $display("[ERR] reg %h expected %h/%h seen %h/%h", idx, exp, HRESP_OKAY, rd, hresp);
        end
    endtask
    // eo of 7fff means no offset expected (nothing selected)
    task automatic chk_dec(input logic [15:0] a, input logic [3:0] es, input logic [14:0] eo);
        logic [3:0] s;
        @(posedge hclk);
        cpu_addr <= a;
        @(posedge hclk);
        #1;
        s = {sel_reg, sel_ram, sel_eeprom, sel_rom};
        cmp_count++;
        if (s !== es || (eo != 15'h7fff && mem_offset !== eo))
        begin
            err_total++;
            $display("[ERR] decode %h expected %b/%h seen %b/%h", a, es, eo, s, mem_offset);
        end
    endtask
    task automatic do_reset(input logic b, input logic a);
        @(posedge hclk);
        hresetn <= 1'b0;
        mode_b_pin <= b;
        mode_a_pin <= a;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (6) @(posedge hclk);
    endtask
    task automatic t_reset_map;
        do_reset(1'b1, 1'b0);
        chk_reg(IDX_INIT, 8'h00);
        chk_reg(IDX_CFG, 8'hc3);
        chk_reg(IDX_NVM, 8'h00);
        chk_reg(IDX_STATUS, 8'h0c);
        chk_dec(16'h0000, 4'b1000, 15'h0000);
        chk_dec(16'h007f, 4'b1000, 15'h007f);
        chk_dec(16'h0080, 4'b0100, 15'h0080);
        chk_dec(16'h0300, 4'b0100, 15'h0000);
        chk_dec(16'h037f, 4'b0100, 15'h007f);
        chk_dec(16'h0380, 4'b0000, 15'h7fff);
        chk_dec(16'ha000, 4'b0001, 15'h0000);
        chk_dec(16'h2000, 4'b0000, 15'h7fff);
        $display("reset map done");
    endtask
    task automatic t_remap_once;
        do_reset(1'b1, 1'b0);
        wr(IDX_INIT, 8'h04);
        chk_dec(16'h4000, 4'b1000, 15'h0000);
        chk_dec(16'h407f, 4'b1000, 15'h007f);
        chk_dec(16'h4080, 4'b0000, 15'h7fff);
        chk_dec(16'h0000, 4'b0100, 15'h0000);
        chk_dec(16'h02ff, 4'b0100, 15'h02ff);
        chk_dec(16'h0300, 4'b0000, 15'h7fff);
        wr(IDX_INIT, 8'h10);
        chk_reg(IDX_INIT, 8'h04);
        chk_reg(IDX_STATUS, 8'h14);
        $display("single write done");
    endtask
    task automatic t_late_write;
        do_reset(1'b1, 1'b1);
        repeat (70) @(posedge hclk);
        wr(IDX_INIT, 8'h10);
        chk_reg(IDX_INIT, 8'h00);
        chk_reg(IDX_STATUS, 8'h05);
        chk_dec(16'h0000, 4'b1000, 15'h0000);
        chk_dec(16'ha000, 4'b0001, 15'h0000);
        wr(IDX_CFG, 8'h41);
        chk_dec(16'ha000, 4'b0000, 15'h7fff);
        wr(IDX_CFG, 8'h43);
        chk_reg(IDX_CFG, 8'h43);
        chk_dec(16'h2000, 4'b0001, 15'h0000);
        chk_dec(16'h7fff, 4'b0001, 15'h5fff);
        chk_dec(16'ha000, 4'b0000, 15'h7fff);
        $display("late write done");
    endtask
    task automatic t_special;
        do_reset(1'b0, 1'b1);
        chk_reg(IDX_CFG, 8'hc1);
        chk_dec(16'ha000, 4'b0000, 15'h7fff);
        wr(IDX_CFG, 8'hc3);
        chk_dec(16'ha000, 4'b0001, 15'h0000);
        repeat (70) @(posedge hclk);
        wr(IDX_INIT, 8'h10);
        chk_dec(16'h1000, 4'b0100, 15'h0000);
        wr(IDX_INIT, 8'h11);
        chk_reg(IDX_INIT, 8'h11);
        chk_reg(IDX_STATUS, 8'h1f);
        chk_dec(16'h1000, 4'b1000, 15'h0000);
        chk_dec(16'h1080, 4'b0100, 15'h0080);
        chk_dec(16'h1300, 4'b0100, 15'h0000);
        chk_dec(16'h137f, 4'b0100, 15'h007f);
        wr(IDX_NVM, 8'h5f);
        chk_reg(IDX_NVM, 8'h50);
        chk_dec(16'h5000, 4'b0010, 15'h0000);
        chk_dec(16'h527f, 4'b0010, 15'h027f);
        chk_dec(16'h5280, 4'b0000, 15'h7fff);
        wr(8'h41, 8'h5a);
        chk_reg(8'h41, 8'h00);
        $display("special mode done");
    endtask
    task automatic t_boot;
        do_reset(1'b0, 1'b0);
        chk_reg(IDX_STATUS, 8'h0e);
        chk_reg(IDX_CFG, 8'hc3);
        chk_dec(16'ha000, 4'b0001, 15'h0000);
        repeat (70) @(posedge hclk);
        wr(IDX_INIT, 8'h20);
        wr(IDX_INIT, 8'h33);
        chk_reg(IDX_INIT, 8'h33);
        chk_dec(16'h3300, 4'b0100, 15'h0000);
        $display("boot mode done");
    endtask
    initial
    begin
        t_reset_map();
        t_remap_once();
        t_late_write();
        t_special();
        t_boot();
        stop_test();
    end
endmodule
`default_nettype wire
